// *** fuse_lock_if.sv ***
// lock state carried from the register file to the fuse read gate
`timescale 1ns/100ps
interface fuse_lock_if;
  logic [3:0] region_lock;
  logic       debug_port_enable;
  modport ctrl (output region_lock, output debug_port_enable);
  modport gate (input region_lock, input debug_port_enable);
endinterface

// *** fuse_lock_pkg.sv ***
// constants for the fuse region lock block
package fuse_lock_pkg;
  localparam int unsigned     ADDR_W          = 12;
  localparam logic [11:0]     DBG_EN_OFFSET   = 12'h020;
  localparam logic [11:0]     LOCK_OFFSET     = 12'h024;
  localparam int unsigned     DBG_EN_BIT      = 0;
  localparam int unsigned     DBG_FIELD_W     = 4;
  localparam int unsigned     LOCK_TEST_BIT   = 0;
  localparam int unsigned     LOCK_LSB        = 1;
  localparam int unsigned     LOCK_COUNT      = 4;
  localparam int unsigned     LK_VENDOR       = 0;
  localparam int unsigned     LK_PRIVATE      = 1;
  localparam int unsigned     LK_USER         = 2;
  localparam int unsigned     LK_PUBLIC       = 3;
  localparam logic [3:0]      DBG_EN_RESET    = 4'h0;
  localparam logic [3:0]      LOCK_RESET      = 4'h0;
  localparam int unsigned     FUSE_ADDR_W     = 9;
  localparam int unsigned     FUSE_DATA_W     = 8;
  localparam logic [8:0]      VENDOR_FIRST    = 9'h020;
  localparam logic [8:0]      VENDOR_LAST     = 9'h07f;
  localparam logic [8:0]      PUBLIC_FIRST    = 9'h080;
  localparam logic [8:0]      PUBLIC_LAST     = 9'h0bf;
  localparam logic [8:0]      USER_FIRST      = 9'h0c0;
  localparam logic [8:0]      USER_LAST       = 9'h1ff;
  localparam logic [7:0]      BLOCKED_VALUE   = 8'h00;
  localparam logic [1:0]      HTRANS_NONSEQ   = 2'h2;
  localparam logic            HRESP_OKAY      = 1'b0;
endpackage

// *** fuse_read_gate.sv ***
// fuse read path that masks locked regions
`timescale 1ns/100ps
module fuse_read_gate (
  input  wire logic                 hclk,          // system clock
  input  wire logic                 hresetn,       // async reset, active low
  fuse_lock_if.gate                 lk,            // lock state
  input  wire logic                 fuse_rd_en,    // read strobe
  input  wire logic [8:0]           fuse_rd_addr,  // fuse byte address
  input  wire logic [7:0]           fuse_raw_data, // array contents
  output logic      [7:0]           fuse_rd_data,  // gated data
  output logic                      fuse_rd_valid  // data valid pulse
);
  import fuse_lock_pkg::*;

  logic in_vendor;
  logic in_private;
  logic in_public;
  logic in_user;
  logic blocked;

  assign in_private = fuse_rd_addr < VENDOR_FIRST;
  assign in_vendor  = fuse_rd_addr >= VENDOR_FIRST && fuse_rd_addr <= VENDOR_LAST;
  assign in_public  = fuse_rd_addr >= PUBLIC_FIRST && fuse_rd_addr <= PUBLIC_LAST;
  assign in_user    = fuse_rd_addr >= USER_FIRST && fuse_rd_addr <= USER_LAST;

  // debug access blocks the key and user areas only, not the vendor area
  assign blocked = (in_vendor && lk.region_lock[LK_VENDOR])                        // RULE4
                || (in_private && (lk.region_lock[LK_PRIVATE] || lk.debug_port_enable)) // RULE3
                || (in_public && (lk.region_lock[LK_PUBLIC] || lk.debug_port_enable))   // RULE1
                || (in_user && (lk.region_lock[LK_USER] || lk.debug_port_enable));      // RULE2

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse_rd_data <= BLOCKED_VALUE;
    end else if (fuse_rd_en) begin
      fuse_rd_data <= blocked ? BLOCKED_VALUE : fuse_raw_data; // RULE6 RULE7
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse_rd_valid <= 1'b0;
    end else begin
      fuse_rd_valid <= fuse_rd_en;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_public_blocked: assert property (fuse_rd_en && in_public && lk.region_lock[LK_PUBLIC]
    |=> fuse_rd_valid && fuse_rd_data == BLOCKED_VALUE) else $error("public read leaked"); // RULE1
  a_user_blocked: assert property (fuse_rd_en && in_user && lk.region_lock[LK_USER]
    |=> fuse_rd_data == BLOCKED_VALUE) else $error("user read leaked"); // RULE2
  a_private_blocked: assert property (fuse_rd_en && in_private && lk.region_lock[LK_PRIVATE]
    |=> fuse_rd_data == BLOCKED_VALUE) else $error("private read leaked"); // RULE3
  a_vendor_gate: assert property (fuse_rd_en && in_vendor
    |=> fuse_rd_data == ($past(lk.region_lock[LK_VENDOR]) ? BLOCKED_VALUE
        : $past(fuse_raw_data))) else $error("vendor read wrong"); // RULE4
  a_debug_blocks: assert property (fuse_rd_en && lk.debug_port_enable && !in_vendor
    |=> fuse_rd_data == BLOCKED_VALUE) else $error("debug read leaked"); // RULE6
  a_open_passes: assert property (fuse_rd_en && !blocked
    |=> fuse_rd_data == $past(fuse_raw_data)) else $error("open read altered"); // RULE7

  c_blocked_read: cover property (fuse_rd_en && blocked && fuse_raw_data != BLOCKED_VALUE);
  c_debug_read: cover property (fuse_rd_en && lk.debug_port_enable && in_user);
endmodule

// *** fuse_region_lock_register.sv ***
// ahb-lite register file for fuse region locks and debug enable
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: public key lock blocks bytes 128-191
// RULE2: lock bit 3 blocks user bytes 192-511
// RULE3: lock bit 2 blocks private key reads
// RULE4: lock bit 1 blocks vendor bytes 32-127
// RULE5: each lock bit writable once per reset
// RULE6: debug enable blocks key and user regions
// RULE7: blocked reads return a fixed value
// RULE8: lock bits reset to zero
// RULE9: debug enable is bit 0 at 20h
// RULE10: test and reserved bits read zero; bits 3:1 at 20h are stored and read back as written
module fuse_region_lock_register (
  input  wire logic                                hclk,              // system clock
  input  wire logic                                hresetn,           // async reset, active low
  input  wire logic                                hsel,              // slave select
  input  wire logic [fuse_lock_pkg::ADDR_W-1:0]    haddr,             // byte address
  input  wire logic [1:0]                          htrans,            // transfer type
  input  wire logic                                hwrite,            // write when high
  input  wire logic [2:0]                          hsize,             // transfer size
  input  wire logic [31:0]                         hwdata,            // write data
  input  wire logic                                hready,            // bus ready in
  output logic                                     hreadyout,         // always ready
  output logic                                     hresp,             // always okay
  output logic      [31:0]                         hrdata,            // read data
  input  wire logic                                fuse_rd_en,        // fuse read strobe
  input  wire logic [fuse_lock_pkg::FUSE_ADDR_W-1:0] fuse_rd_addr,    // fuse byte address
  input  wire logic [fuse_lock_pkg::FUSE_DATA_W-1:0] fuse_raw_data,   // array contents
  output logic      [fuse_lock_pkg::FUSE_DATA_W-1:0] fuse_rd_data,    // gated fuse data
  output logic                                     fuse_rd_valid,     // gated data valid
  output logic                                     debug_port_enable  // debug port on
);
  import fuse_lock_pkg::*;

  logic [ADDR_W-1:0]      addr_q;
  logic                   wr_pend;
  logic                   rd_pend;
  logic [DBG_FIELD_W-1:0] dbg_ctrl;
  logic [LOCK_COUNT-1:0]  lock;
  logic [LOCK_COUNT-1:0]  lock_done;
  logic                   lock_wr;
  logic                   dbg_wr;
  logic                   take;

  fuse_lock_if lock_bus ();

  assign take      = hsel && hready && htrans == HTRANS_NONSEQ;
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign lock_wr   = wr_pend && addr_q == LOCK_OFFSET;
  assign dbg_wr    = wr_pend && addr_q == DBG_EN_OFFSET;

  // address phase captured; the data phase always completes in one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q  <= '0;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      addr_q  <= take ? {haddr[ADDR_W-1:2], 2'h0} : addr_q;
      wr_pend <= take && hwrite;
      rd_pend <= take && !hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbg_ctrl <= DBG_EN_RESET;
    end else if (dbg_wr) begin
      dbg_ctrl <= hwdata[DBG_FIELD_W-1:0]; // RULE9
    end
  end

  // the first write after reset freezes each lock bit, whatever value it carries
  for (genvar k = 0; k < LOCK_COUNT; k++) begin : g_lock
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lock[k]      <= LOCK_RESET[k]; // RULE8
        lock_done[k] <= 1'b0;
      end else if (lock_wr && !lock_done[k]) begin
        lock[k]      <= hwdata[LOCK_LSB+k]; // RULE5
        lock_done[k] <= 1'b1;
      end
    end
  end

  // read mux sits on flops only, so a write is visible to the very next read
  always_comb begin
    hrdata = '0;
    if (rd_pend) begin
      unique case (addr_q)
        DBG_EN_OFFSET: hrdata[DBG_FIELD_W-1:0] = dbg_ctrl;
        LOCK_OFFSET:   hrdata[LOCK_LSB +: LOCK_COUNT] = lock; // RULE10
        default:       hrdata = '0;
      endcase
    end
  end

  assign debug_port_enable            = dbg_ctrl[DBG_EN_BIT]; // RULE9
  assign lock_bus.region_lock       = lock;
  assign lock_bus.debug_port_enable = dbg_ctrl[DBG_EN_BIT]; // RULE6

  fuse_read_gate u_gate (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .lk            (lock_bus.gate),
    .fuse_rd_en    (fuse_rd_en),
    .fuse_rd_addr  (fuse_rd_addr),
    .fuse_raw_data (fuse_raw_data),
    .fuse_rd_data  (fuse_rd_data),
    .fuse_rd_valid (fuse_rd_valid)
  );

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_lock_write_once: assert property (((lock ^ $past(lock)) & $past(lock_done)) == '0)
    else $error("frozen lock bit changed"); // RULE5
  a_lock_first_write: assert property (lock_wr && lock_done == '0
    |=> lock == $past(hwdata[LOCK_LSB +: LOCK_COUNT]) && lock_done == '1)
    else $error("first lock write not taken"); // RULE5
  a_lock_reset_open: assert property ((lock & ~lock_done) == '0)
    else $error("lock set without a write"); // RULE8
  a_test_bit_zero: assert property (rd_pend && addr_q == LOCK_OFFSET
    |-> hrdata[LOCK_TEST_BIT] == 1'b0 && hrdata[31:LOCK_LSB+LOCK_COUNT] == '0)
    else $error("test or reserved bit nonzero"); // RULE10
  a_debug_bit_write: assert property (dbg_wr
    |=> debug_port_enable == $past(hwdata[DBG_EN_BIT]))
    else $error("debug enable not written"); // RULE9
  a_lock_readback: assert property (rd_pend && addr_q == LOCK_OFFSET
    |-> hrdata[LOCK_LSB +: LOCK_COUNT] == lock) else $error("lock readback wrong"); // RULE5

  c_lock_written: cover property (lock_wr ##1 lock_wr);
  c_lock_read: cover property (lock_wr ##[1:4] rd_pend && addr_q == LOCK_OFFSET);
  c_debug_on: cover property ($rose(debug_port_enable));
endmodule

// *** tb_fuse_region_lock_register.sv ***
// self-checking bench for the fuse region lock register
`timescale 1ns/100ps
module tb_fuse_region_lock_register;
  import fuse_lock_pkg::*;
  typedef struct {logic [8:0] a; logic [7:0] raw; logic [7:0] exp;} row_type;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  wire logic   hready;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        fuse_rd_en = 1'b0;
  logic        fuse_rd_valid;
  logic        debug_port_enable;
  logic [8:0]  fuse_rd_addr = 9'h000;
  logic [7:0]  fuse_raw_data = 8'h00;
  logic [7:0]  fuse_rd_data;
  logic [4:0]  lk = 5'h00;
  logic        dbg = 1'b0;
  int          errors = 0;
  int          n_compared = 0;
  // region edges, unlocked: every byte passes through
  row_type     rows[8] = '{'{9'h000, 8'ha5, 8'ha5}, '{9'h01f, 8'h3c, 8'h3c},
                           '{9'h020, 8'h5a, 8'h5a}, '{9'h07f, 8'hc3, 8'hc3},
                           '{9'h080, 8'h81, 8'h81}, '{9'h0bf, 8'h7e, 8'h7e},
                           '{9'h0c0, 8'h69, 8'h69}, '{9'h1ff, 8'h96, 8'h96}};

  // one slave on the bus, so its ready is the bus ready
  assign hready = hreadyout;

  always #50 hclk = ~hclk;

  fuse_region_lock_register DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fuse_rd_en(fuse_rd_en),
    .fuse_rd_addr(fuse_rd_addr), .fuse_raw_data(fuse_raw_data),
    .fuse_rd_data(fuse_rd_data), .fuse_rd_valid(fuse_rd_valid),
    .debug_port_enable(debug_port_enable)
  );

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // entered right after a rising edge; data taken while it stands
  task automatic ahb(logic wr, logic [11:0] a, logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    // taken in the active region of the closing edge, before the slave's flops move
    rd = hrdata;
    chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    @(posedge hclk);
  endtask

  // expected byte from the lock image and the debug enable
  function automatic logic [7:0] model(logic [8:0] a, logic [7:0] raw);
    logic b;
    b = (a < 9'd32) ? (lk[2] | dbg) : (a < 9'd128) ? lk[1] :
        (a < 9'd192) ? (lk[4] | dbg) : (lk[3] | dbg);
    return b ? BLOCKED_VALUE : raw;
  endfunction

  task automatic fchk(logic [8:0] a, logic [7:0] raw, logic [7:0] e);
    fuse_rd_en    <= 1'b1;
    fuse_rd_addr  <= a;
    fuse_raw_data <= raw;
    @(posedge hclk);
    fuse_rd_en    <= 1'b0;
    // stale raw data would show up as the inverse
    fuse_raw_data <= ~raw;
    @(negedge hclk);
    chk("fuse_rd_valid", 32'h1, {31'h0, fuse_rd_valid});
    chk("fuse_rd_data", {24'h0, e}, {24'h0, fuse_rd_data});
    @(posedge hclk);
  endtask

  task automatic sweep();
    foreach (rows[i]) fchk(rows[i].a, rows[i].raw, model(rows[i].a, rows[i].raw));
  endtask

  initial begin
    #(2000 * 100);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    chk("debug_port_enable", 32'h0, {31'h0, debug_port_enable});
    ahb(1'b0, LOCK_OFFSET, 32'h0);
    chk("lock reset", 32'h0, rd);
    ahb(1'b0, DBG_EN_OFFSET, 32'h0);
    chk("debug reset", 32'h0, rd);
    foreach (rows[i]) fchk(rows[i].a, rows[i].raw, rows[i].exp);
    ahb(1'b1, LOCK_OFFSET, 32'h0000000b);
    lk = 5'h0a;
    ahb(1'b0, LOCK_OFFSET, 32'h0);
    chk("lock test bit", 32'h0000000a, rd);
    ahb(1'b1, LOCK_OFFSET, 32'hffffffff);
    ahb(1'b0, LOCK_OFFSET, 32'h0);
    chk("lock frozen", 32'h0000000a, rd);
    sweep();
    sweep();
    ahb(1'b1, DBG_EN_OFFSET, 32'h00000001);
    dbg = 1'b1;
    ahb(1'b0, DBG_EN_OFFSET, 32'h0);
    chk("debug reg", 32'h1, rd);
    chk("debug_port_enable", 32'h1, {31'h0, debug_port_enable});
    sweep();
    ahb(1'b1, 12'h028, 32'hffffffff);
    ahb(1'b0, 12'h028, 32'h0);
    chk("unmapped", 32'h0, rd);
    // second reset in mid-run unfreezes the locks
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    lk = 5'h00;
    dbg = 1'b0;
    ahb(1'b0, LOCK_OFFSET, 32'h0);
    chk("lock after reset", 32'h0, rd);
    ahb(1'b1, LOCK_OFFSET, 32'h00000014);
    lk = 5'h14;
    ahb(1'b0, LOCK_OFFSET, 32'h0);
    chk("lock keys", 32'h00000014, rd);
    sweep();
    sweep();
    tally_and_finish();
  end
endmodule
